/* File: hdl/csw_defs.vh */
// csw_defs.vh: constants for the chip select and wait state unit
// assumes inclusion by the design files of the csw block only
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH

// register map: one byte register per index, 4 bits of address
`define CSW_ADDR_W        4
`define CSW_REG_CTL0      4'h0
`define CSW_REG_CTL1      4'h1
`define CSW_REG_CTL2      4'h2
`define CSW_REG_CTL3      4'h3
`define CSW_REG_LBR0      4'h4
`define CSW_REG_LBR1      4'h5
`define CSW_REG_LBR2      4'h6
`define CSW_REG_LBR3      4'h7
`define CSW_REG_UBR0      4'h8
`define CSW_REG_UBR1      4'h9
`define CSW_REG_UBR2      4'hA
`define CSW_REG_UBR3      4'hB
`define CSW_REG_STATUS    4'hC

// control register fields
`define CSW_CTL_EN        3
`define CSW_CTL_IO        4
`define CSW_CTL_WAIT_HI   7
`define CSW_CTL_WAIT_LO   5

// reset values
`define CSW_CTL_RST       8'h00
`define CSW_LBR_RST       8'h00
`define CSW_UBR0_RST      8'hFF
`define CSW_UBRN_RST      8'h00

// wait counter end points
`define CSW_WAIT_NONE     3'h0
`define CSW_WAIT_STEP     3'h1

// idle levels of read data, stall pin and unused status bits
`define CSW_RDATA_IDLE    8'h00
`define CSW_PIN_IDLE      1'b1
`define CSW_STATUS_PAD    3'h0

// i/o space owned by on-chip peripherals: high byte of address
`define CSW_IO_INT_HI     8'h00

// address fields
`define CSW_MEM_HI        23
`define CSW_MEM_LO        16
`define CSW_IO_HI         15
`define CSW_IO_LO         8

`define CSW_NUM_SEL       4

`endif

/* File: hdl/csw_sync.v */
// csw_sync.v: three-stage input synchroniser with agreement filter
// assumes an asynchronous pin input and the system clock domain
`timescale 1ns/1ns
`default_nettype none

module csw_sync (
  // clock and control
  input  wire clk,
  input  wire reset,
  input  wire ce,
  // pin and filtered level
  input  wire pin,
  input  wire rst_val,
  output reg  level
);

  reg s1;
  reg s2;
  reg s3;

  // s1 feeds only s2; level moves once s2 and s3 agree
  always @(posedge clk) begin
    if (reset) begin
      s1    <= rst_val;
      s2    <= rst_val;
      s3    <= rst_val;
      level <= rst_val;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end

endmodule // csw_sync

`default_nettype wire

/* File: hdl/csw_unit.v */
// csw_unit.v: four external chip selects with programmable wait states
// assumes cpu access request/done handshake on the system clock and
// a plain register port driven from the same clock
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.vh"

module csw_unit (
  // clock and control
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  // cpu access request
  input  wire        acc_req,
  input  wire        acc_io,
  input  wire        acc_write,
  input  wire [23:0] acc_addr,
  input  wire        int_ram_hit,
  input  wire        int_flash_hit,
  output reg         acc_done,
  output reg         acc_external,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  // external bus pins
  input  wire        stall_in_n,
  output reg         ext_select0_n,
  output reg         ext_select1_n,
  output reg         ext_select2_n,
  output reg         ext_select3_n,
  output reg         memory_request_n,
  output reg         io_request_n,
  output reg         read_strobe_n,
  output reg         write_strobe_n
);

  localparam ST_IDLE  = 2'b00;
  localparam ST_WAIT  = 2'b01;
  localparam ST_STALL = 2'b10;
  localparam ST_DONE  = 2'b11;

  reg  [7:0] select_control     [0:3];
  reg  [7:0] select_lower_bound [0:3];
  reg  [7:0] select_upper_bound [0:3];
  reg  [1:0] state;
  reg  [2:0] wait_cnt;
  reg        stall_q;
  wire       stall_level;

  reg  [3:0] match;
  reg  [3:0] win;
  reg  [2:0] win_wait;
  reg  [1:0] next_state;
  reg  [2:0] next_wait_cnt;
  reg        next_done;
  reg        next_external;
  reg  [3:0] next_select_n;
  reg        next_mem_req_n;
  reg        next_io_req_n;
  reg        next_rd_strobe_n;
  reg        next_wr_strobe_n;
  reg  [7:0] status_word;
  reg  [7:0] read_word;
  integer    i;
  integer    j;
  integer    r;

  // pin passes five flops (s1, s2, s3, level, stall_q) before the wait logic looks at it
  csw_sync u_stall_sync (
    .clk     (clk),
    .reset   (reset),
    .ce      (ce),
    .pin     (stall_in_n),
    .rst_val (`CSW_PIN_IDLE),
    .level   (stall_level)
  );

  function sel_match;
    input [7:0]  ctl;
    input [7:0]  lbr;
    input [7:0]  ubr;
    input        io;
    input [23:0] addr;
    input        ram;
    input        flash;
    begin
      if (!ctl[`CSW_CTL_EN])
        sel_match = 1'b0;
      else if (ctl[`CSW_CTL_IO])
        sel_match = io
          && addr[`CSW_IO_HI:`CSW_IO_LO] == lbr
          && addr[`CSW_IO_HI:`CSW_IO_LO] != `CSW_IO_INT_HI;
      else
        sel_match = !io && !ram && !flash
          && addr[`CSW_MEM_HI:`CSW_MEM_LO] >= lbr
          && addr[`CSW_MEM_HI:`CSW_MEM_LO] <= ubr;
    end
  endfunction

  // decode and priority
  always @* begin
    match = 4'h0;
    for (i = 0; i < `CSW_NUM_SEL; i = i + 1)
      match[i] = sel_match(select_control[i], select_lower_bound[i],
                           select_upper_bound[i], acc_io, acc_addr,
                           int_ram_hit, int_flash_hit);
    win = match & (~match + 4'h1);
  end

  always @* begin
    win_wait = `CSW_WAIT_NONE;
    for (j = 0; j < `CSW_NUM_SEL; j = j + 1)
      if (win[j])
        win_wait = select_control[j][`CSW_CTL_WAIT_HI:`CSW_CTL_WAIT_LO];
  end

  // register writes; status and unmapped offsets are read-only
  always @(posedge clk) begin
    if (reset) begin
      for (r = 0; r < `CSW_NUM_SEL; r = r + 1) begin
        select_control[r]     <= `CSW_CTL_RST;
        select_lower_bound[r] <= `CSW_LBR_RST;
        select_upper_bound[r] <= `CSW_UBRN_RST;
      end
      select_upper_bound[0] <= `CSW_UBR0_RST;
    end else if (ce && reg_write) begin
      case (reg_addr)
        `CSW_REG_CTL0: select_control[0]     <= reg_wdata;
        `CSW_REG_CTL1: select_control[1]     <= reg_wdata;
        `CSW_REG_CTL2: select_control[2]     <= reg_wdata;
        `CSW_REG_CTL3: select_control[3]     <= reg_wdata;
        `CSW_REG_LBR0: select_lower_bound[0] <= reg_wdata;
        `CSW_REG_LBR1: select_lower_bound[1] <= reg_wdata;
        `CSW_REG_LBR2: select_lower_bound[2] <= reg_wdata;
        `CSW_REG_LBR3: select_lower_bound[3] <= reg_wdata;
        `CSW_REG_UBR0: select_upper_bound[0] <= reg_wdata;
        `CSW_REG_UBR1: select_upper_bound[1] <= reg_wdata;
        `CSW_REG_UBR2: select_upper_bound[2] <= reg_wdata;
        `CSW_REG_UBR3: select_upper_bound[3] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read word; status is built from the registered pins
  always @* begin
    status_word = {`CSW_STATUS_PAD, ~stall_q, ~ext_select3_n,
                   ~ext_select2_n, ~ext_select1_n, ~ext_select0_n};
    case (reg_addr)
      `CSW_REG_CTL0:   read_word = select_control[0];
      `CSW_REG_CTL1:   read_word = select_control[1];
      `CSW_REG_CTL2:   read_word = select_control[2];
      `CSW_REG_CTL3:   read_word = select_control[3];
      `CSW_REG_LBR0:   read_word = select_lower_bound[0];
      `CSW_REG_LBR1:   read_word = select_lower_bound[1];
      `CSW_REG_LBR2:   read_word = select_lower_bound[2];
      `CSW_REG_LBR3:   read_word = select_lower_bound[3];
      `CSW_REG_UBR0:   read_word = select_upper_bound[0];
      `CSW_REG_UBR1:   read_word = select_upper_bound[1];
      `CSW_REG_UBR2:   read_word = select_upper_bound[2];
      `CSW_REG_UBR3:   read_word = select_upper_bound[3];
      `CSW_REG_STATUS: read_word = status_word;
      default:         read_word = `CSW_RDATA_IDLE;
    endcase
  end

  // read data stands for the one cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (reset)
      reg_rdata <= `CSW_RDATA_IDLE;
    else if (ce) begin
      if (reg_read)
        reg_rdata <= read_word;
      else
        reg_rdata <= `CSW_RDATA_IDLE;
    end
  end

  // access sequencer: strobes held through waits and stall
  always @* begin
    next_state       = state;
    next_wait_cnt    = wait_cnt;
    next_done        = 1'b0;
    next_external    = acc_external;
    next_select_n    = {ext_select3_n, ext_select2_n,
                        ext_select1_n, ext_select0_n};
    next_mem_req_n   = memory_request_n;
    next_io_req_n    = io_request_n;
    next_rd_strobe_n = read_strobe_n;
    next_wr_strobe_n = write_strobe_n;
    case (state)
      ST_IDLE:
        if (acc_req) begin
          next_select_n = ~win;
          next_external = |win;
          if (|win) begin
            next_mem_req_n   = acc_io;
            next_io_req_n    = ~acc_io;
            next_rd_strobe_n = acc_write;
            next_wr_strobe_n = ~acc_write;
            next_wait_cnt    = win_wait;
            next_state       = ST_WAIT;
          end else begin
            next_done        = 1'b1;
          end
        end
      ST_WAIT:
        if (wait_cnt != `CSW_WAIT_NONE)
          next_wait_cnt = wait_cnt - `CSW_WAIT_STEP;
        else if (stall_q)
          next_state = ST_STALL;
        else
          next_state = ST_DONE;
      ST_STALL:
        // one extra cycle per cycle the pin stays low
        if (!stall_q)
          next_state = ST_DONE;
      ST_DONE: begin
        next_select_n    = {`CSW_NUM_SEL{1'b1}};
        next_mem_req_n   = 1'b1;
        next_io_req_n    = 1'b1;
        next_rd_strobe_n = 1'b1;
        next_wr_strobe_n = 1'b1;
        next_done        = 1'b1;
        next_state       = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // every pin comes straight from a flop, so no decode glitch escapes
  always @(posedge clk) begin
    if (reset) begin
      state            <= ST_IDLE;
      wait_cnt         <= `CSW_WAIT_NONE;
      stall_q          <= 1'b0;
      acc_done         <= 1'b0;
      acc_external     <= 1'b0;
      ext_select0_n    <= 1'b1;
      ext_select1_n    <= 1'b1;
      ext_select2_n    <= 1'b1;
      ext_select3_n    <= 1'b1;
      memory_request_n <= 1'b1;
      io_request_n     <= 1'b1;
      read_strobe_n    <= 1'b1;
      write_strobe_n   <= 1'b1;
    end else if (ce) begin
      stall_q          <= ~stall_level;
      state            <= next_state;
      wait_cnt         <= next_wait_cnt;
      acc_done         <= next_done;
      acc_external     <= next_external;
      ext_select0_n    <= next_select_n[0];
      ext_select1_n    <= next_select_n[1];
      ext_select2_n    <= next_select_n[2];
      ext_select3_n    <= next_select_n[3];
      memory_request_n <= next_mem_req_n;
      io_request_n     <= next_io_req_n;
      read_strobe_n    <= next_rd_strobe_n;
      write_strobe_n   <= next_wr_strobe_n;
    end
  end

endmodule // csw_unit

`default_nettype wire

/* File: tb/csw_unit_sva.sv */
// csw_unit_sva.sv: port assertions for csw_unit
// assumes one clock and the synchronous reset of csw_unit
`timescale 1ns/1ns
`default_nettype none
module csw_unit_sva (
  // clock and control
  input wire logic        clk,
  input wire logic        reset,
  // cpu side
  input wire logic        acc_io,
  input wire logic        acc_write,
  input wire logic [23:0] acc_addr,
  input wire logic        int_ram_hit,
  input wire logic        int_flash_hit,
  input wire logic        acc_done,
  // pins
  input wire logic        stall_in_n,
  input wire logic        ext_select0_n,
  input wire logic        ext_select1_n,
  input wire logic        ext_select2_n,
  input wire logic        ext_select3_n,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n
);
  logic [3:0] sel;
  assign sel = ~{ext_select3_n, ext_select2_n, ext_select1_n, ext_select0_n};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_one_select: assert property ($onehot0(sel))
    else $error("two selects low");
  a_mem_cmd: assert property (!memory_request_n |-> !acc_io && sel != 0)
    else $error("memory request wrong");
  a_io_cmd: assert property (!io_request_n |-> acc_io && sel != 0)
    else $error("io request wrong");
  a_io_page: assert property (!io_request_n |-> acc_addr[15:8] != 0)
    else $error("select in peripheral page");
  a_int_first: assert property (!memory_request_n |->
    !int_ram_hit && !int_flash_hit)
    else $error("select over internal memory");
  a_dir_strobe: assert property (!write_strobe_n |->
    acc_write && read_strobe_n)
    else $error("write strobe wrong");
  a_min_wait: assert property (sel != 0 && $past(sel) == 0 |->
    !acc_done [*2])
    else $error("access too short");
  a_stall_hold: assert property (!stall_in_n [*7] ##0 sel != 0 |=>
    !acc_done)
    else $error("done during stall");
  a_resume: assert property ($rose(stall_in_n) && sel != 0 |->
    ##[1:14] acc_done)
    else $error("no resume after stall");
  a_done_free: assert property (acc_done |->
    sel == 0 && memory_request_n && io_request_n)
    else $error("pins low at done");
endmodule // csw_unit_sva
bind csw_unit csw_unit_sva csw_unit_sva_i (.clk, .reset, .acc_io, .acc_write,
  .acc_addr, .int_ram_hit, .int_flash_hit, .acc_done, .stall_in_n,
  .ext_select0_n, .ext_select1_n, .ext_select2_n, .ext_select3_n,
  .memory_request_n, .io_request_n, .read_strobe_n, .write_strobe_n);
`default_nettype wire

/* File: tb/csw_periph.sv */
// csw_periph.sv: slow peripheral that stalls its accesses
// assumes a pulled-up stall line; hold of zero never stalls
`timescale 1ns/1ns
`default_nettype none
module csw_periph (
  // clock and select
  input  wire logic       clk,
  input  wire logic       sel_n,
  input  wire logic [3:0] hold,
  // stall pin
  output var  logic       stall_n
);
  logic [3:0] cnt = 4'h0;
  logic       sel_q = 1'b1;
  initial stall_n = 1'b1;
  always @(posedge clk) begin
    sel_q <= sel_n;
    if (sel_q && !sel_n)
      cnt <= hold;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    stall_n <= (cnt == 4'h0);
  end
endmodule // csw_periph
`default_nettype wire

/* File: tb/csw_unit_bench.sv */
// csw_unit_bench.sv: register and access sequences for csw_unit
// assumes csw_periph on select 3 and the checker bound in
`timescale 1ns/1ns
`default_nettype none
module csw_unit_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic acc_req = 1'b0;
  logic acc_io = 1'b0;
  logic acc_write = 1'b0;
  logic [23:0] acc_addr = 24'h000000;
  logic int_ram_hit = 1'b0;
  logic int_flash_hit = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [3:0] hold = 4'h0;
  logic [7:0] reg_rdata;
  logic acc_done, acc_external, stall_in_n, memory_request_n, io_request_n;
  logic ext_select0_n, ext_select1_n, ext_select2_n, ext_select3_n;
  logic read_strobe_n, write_strobe_n;
  int mismatches = 0;
  int checks = 0;
  always #50 clk = ~clk;
  csw_unit csw_unit_i (.clk, .reset, .ce, .acc_req, .acc_io, .acc_write,
    .acc_addr, .int_ram_hit, .int_flash_hit, .acc_done, .acc_external,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .stall_in_n,
    .ext_select0_n, .ext_select1_n, .ext_select2_n, .ext_select3_n,
    .memory_request_n, .io_request_n, .read_strobe_n, .write_strobe_n);
  csw_periph csw_periph_i (.clk, .sel_n(ext_select3_n), .hold,
    .stall_n(stall_in_n));
  task automatic chk(input logic [23:0] s, e, input string n);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e, "rdata");
  endtask
  // s: selects expected low, ws: programmed waits
  task automatic acc(input logic io, w, input logic [23:0] a,
      input logic [1:0] hit, input logic [3:0] s, input int ws);
    int k;
    logic [7:0] pins;
    logic e;
    e = (s != 4'h0);
    @(posedge clk);
    {acc_io, acc_write, acc_addr, int_ram_hit, int_flash_hit} <= {io, w, a, hit};
    acc_req <= 1'b1;
    for (k = 1; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (k == 1) pins = {ext_select3_n, ext_select2_n, ext_select1_n,
        ext_select0_n, memory_request_n, io_request_n, read_strobe_n,
        write_strobe_n};
      if (acc_done === 1'b1) break;
    end
    acc_req <= 1'b0;
    if (k == 40) begin
      mismatches++;
      close_out();
    end else begin
      chk(pins, {~s, e ? io : 1'b1, e ? !io : 1'b1, e ? w : 1'b1,
        e ? !w : 1'b1}, "pins");
      chk(24'(acc_external), 24'(e), "external");
      if (hold != 4'h0) chk(24'(k > ws + 3), 24'h000001, "stretch");
      else chk(24'(k), 24'(e ? ws + 3 : 1), "cycles");
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 14; i++)
      rd(i[3:0], i == 8 ? 8'hFF : i == 12 ? 8'h10 : 8'h00);
    acc(0, 0, 24'h7F0000, 2'b00, 4'h0, 0);
    wr(4'h0, 8'h08);
    wr(4'h8, 8'h7F);
    wr(4'h1, 8'h48);
    wr(4'h9, 8'h9F);
    wr(4'h2, 8'h38);
    wr(4'h6, 8'h12);
    wr(4'h3, 8'hE8);
    wr(4'h7, 8'hA0);
    wr(4'hB, 8'hA0);
    wr(4'hC, 8'hFF);
    rd(4'h3, 8'hE8);
    rd(4'hC, 8'h10);
    acc(0, 0, 24'h7FFFFF, 2'b00, 4'h1, 0);
    acc(0, 1, 24'h800000, 2'b00, 4'h2, 2);
    acc(0, 0, 24'h9F0000, 2'b00, 4'h2, 2);
    acc(0, 1, 24'hA0FFFF, 2'b00, 4'h8, 7);
    acc(0, 0, 24'hA10000, 2'b00, 4'h0, 0);
    acc(0, 0, 24'h100000, 2'b10, 4'h0, 0);
    acc(0, 0, 24'h100000, 2'b01, 4'h0, 0);
    acc(0, 0, 24'h12FFFF, 2'b00, 4'h1, 0);
    acc(1, 1, 24'hFF1234, 2'b00, 4'h4, 1);
    acc(1, 0, 24'h001300, 2'b00, 4'h0, 0);
    hold <= 4'hA;
    acc(0, 0, 24'hA05555, 2'b00, 4'h8, 7);
    hold <= 4'h0;
    wr(4'h6, 8'h00);
    acc(1, 0, 24'h000012, 2'b00, 4'h0, 0);
    close_out();
  end
endmodule // csw_unit_bench
`default_nettype wire
